// File: rtl/crr_evt_if.sv
// Interface carrying reset and wake-up events to the register bank
`timescale 1ns/1ps
`default_nettype none
interface crr_evt_if;
    crr_pkg::crr_event_t kind;
    logic high_prio;
    modport src (output kind, output high_prio);
    modport dst (input kind, input high_prio);
endinterface : crr_evt_if
`default_nettype wire

// File: rtl/crr_evt_sync.sv
// Synchronises reset-type and wake-up pins into one-cycle events
`timescale 1ns/1ps
`default_nettype none
module crr_evt_sync (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Raw event levels from the reset unit
    input wire logic i_por,
    input wire logic i_hard,
    input wire logic i_wake_wdt,
    input wire logic i_wake_irq,
    input wire logic i_irq_high,
    // Event out
    crr_evt_if.src evt
);
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    wire [4:0] rise = s2 & ~s3;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s1 <= 5'h00;
            s2 <= 5'h00;
            s3 <= 5'h00;
        end else begin
            s1 <= {i_irq_high, i_wake_irq, i_wake_wdt, i_hard, i_por};
            s2 <= s1;
            s3 <= s2;
        end
    end
    // Priority: power-on over hard reset over wake-ups
    always_comb begin
        if (rise[0]) evt.kind = crr_pkg::EV_POR;
        else if (rise[1]) evt.kind = crr_pkg::EV_HARD;
        else if (rise[3]) evt.kind = crr_pkg::EV_WAKE_IRQ;
        else if (rise[2]) evt.kind = crr_pkg::EV_WAKE_WDT;
        else evt.kind = crr_pkg::EV_NONE;
    end
    assign evt.high_prio = s2[4];
endmodule : crr_evt_sync
`default_nettype wire

// File: rtl/crr_pkg.sv
// Package of register map, reset values and wake-up constants
`default_nettype none
package crr_pkg;
    localparam int NREG = 22;
    localparam logic [7:0] ADDR_STEP = 8'h04;
    // Register indices; byte address is four times the index
    localparam logic [4:0] IX_TOP_U = 5'h00;
    localparam logic [4:0] IX_TOP_H = 5'h01;
    localparam logic [4:0] IX_TOP_L = 5'h02;
    localparam logic [4:0] IX_STKP = 5'h03;
    localparam logic [4:0] IX_PC_LATCH_U = 5'h04;
    localparam logic [4:0] IX_PC_LATCH_H = 5'h05;
    localparam logic [4:0] IX_PC_LOW = 5'h06;
    localparam logic [4:0] IX_TBLU = 5'h07;
    localparam logic [4:0] IX_IRQ_CTL = 5'h0D;
    localparam logic [4:0] IX_IRQ_CTL3 = 5'h0F;
    localparam logic [4:0] IX_PCU = 5'h16;
    localparam logic [4:0] IX_PCH = 5'h17;
    localparam logic [4:0] IX_EVT = 5'h18;
    localparam logic [4:0] IX_LAST = 5'h18;
    // Implemented-bit masks, index order 0..21
    localparam logic [7:0] IMPL [NREG] = '{
        8'h1F, 8'hFF, 8'hFF, 8'hDF, 8'h1F, 8'hFF, 8'hFF, 8'h3F,
        8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF,
        8'h0F, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h0F};
    // Bits forced on power-on/brown-out resets
    localparam logic [7:0] POR_MASK [NREG] = '{
        8'h1F, 8'hFF, 8'hFF, 8'hDF, 8'h1F, 8'hFF, 8'hFF, 8'h3F,
        8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFE, 8'hFF, 8'hFF,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F};
    // Bits forced on the other hard resets
    localparam logic [7:0] HARD_MASK [NREG] = '{
        8'h1F, 8'hFF, 8'hFF, 8'h1F, 8'h1F, 8'hFF, 8'hFF, 8'h3F,
        8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'hFE, 8'hFF, 8'hFF,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h0F};
    localparam logic [7:0] RST_VAL [NREG] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hC0,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [20:0] VEC_HIGH = 21'h000008;
    localparam logic [20:0] VEC_LOW = 21'h000018;
    localparam logic [20:0] PC_STEP = 21'h000002;
    localparam logic [4:0] STK_MAX = 5'h1F;
    localparam int STK_FULL_BIT = 7;
    localparam int IRQ_EN_HIGH_BIT = 7;
    localparam int IRQ_EN_LOW_BIT = 6;
    // Flag bits set by a wake-up event
    localparam int WDT_FLAG_BIT = 2;
    localparam int IRQ_FLAG_BIT = 1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        EV_NONE = 3'h0, EV_POR = 3'h1, EV_HARD = 3'h3,
        EV_WAKE_WDT = 3'h2, EV_WAKE_IRQ = 3'h6
    } crr_event_t;
endpackage : crr_pkg
`default_nettype wire

// File: rtl/crr_top.sv
// Core special-register bank with reset and wake-up initialisation
//
// Our own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module crr_top (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Reset unit and wake-up pins
    input wire logic i_por,
    input wire logic i_hard,
    input wire logic i_wake_wdt,
    input wire logic i_wake_irq,
    input wire logic i_irq_high,
    // AXI4-Lite write
    input wire logic [7:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    // AXI4-Lite read
    input wire logic [7:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // Status
    output logic o_wake_done
);
    logic rs1;
    logic rst_n;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rs1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1 <= 1'b1;
            rst_n <= rs1;
        end
    end

    crr_evt_if evt ();
    crr_evt_sync u_sync (
        .i_clk(i_clk),
        .i_rst_n(rst_n),
        .i_por(i_por),
        .i_hard(i_hard),
        .i_wake_wdt(i_wake_wdt),
        .i_wake_irq(i_wake_irq),
        .i_irq_high(i_irq_high),
        .evt(evt)
    );

    // Bank: 22 core registers plus PC upper/high bytes
    logic [7:0] regs [crr_pkg::NREG];
    logic [7:0] pcu;
    logic [7:0] pch;
    logic [2:0] evt_last;

    function automatic logic [4:0] idx_of(input logic [7:0] a);
        idx_of = a[6:2];
    endfunction : idx_of

    // Aligned, inside the map and below the upper half of the address space
    function automatic logic map_ok(input logic [7:0] a);
        map_ok = idx_of(a) <= crr_pkg::IX_LAST && a[1:0] == 2'b00 &&
            a[7] == 1'b0;
    endfunction : map_ok

    function automatic logic [7:0] rd_reg(input logic [4:0] i,
        input logic [7:0] r);
        if (i < 5'(crr_pkg::NREG)) rd_reg = r & crr_pkg::IMPL[i];
        else rd_reg = 8'h00;
    endfunction : rd_reg

    wire [20:0] pc = {pcu[4:0], pch, regs[crr_pkg::IX_PC_LOW]};
    wire gie = regs[crr_pkg::IX_IRQ_CTL][crr_pkg::IRQ_EN_HIGH_BIT] |
        regs[crr_pkg::IX_IRQ_CTL][crr_pkg::IRQ_EN_LOW_BIT];
    wire is_irq = evt.kind == crr_pkg::EV_WAKE_IRQ;
    wire is_wdt = evt.kind == crr_pkg::EV_WAKE_WDT;
    wire vec_go = is_irq && gie;
    wire [20:0] vec = evt.high_prio ? crr_pkg::VEC_HIGH : crr_pkg::VEC_LOW;
    wire [20:0] pc_wake = vec_go ? vec : pc + crr_pkg::PC_STEP;
    wire [4:0] sp = regs[crr_pkg::IX_STKP][4:0];
    wire sp_full = sp == crr_pkg::STK_MAX;
    wire [4:0] sp_next = sp_full ? sp : sp + 5'h01;

    // Write channel: take address and data in either order
    logic aw_held;
    logic w_held;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    wire [7:0] aw_now = aw_held ? aw_q : i_awaddr;
    wire [31:0] w_now = w_held ? w_q : i_wdata;
    wire [3:0] ws_now = w_held ? ws_q : i_wstrb;
    wire aw_ok = aw_held | (i_awvalid & o_awready);
    wire w_ok = w_held | (i_wvalid & o_wready);
    wire wr_fire = aw_ok & w_ok & ~o_bvalid;
    wire [4:0] wi = idx_of(aw_now);
    wire wr_map = map_ok(aw_now);
    wire wr_do = wr_fire & wr_map & ws_now[0];

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h0000_0000;
            ws_q <= 4'h0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= crr_pkg::RESP_OKAY;
        end else begin
            o_awready <= ~aw_ok & ~o_bvalid & ~(i_awvalid & o_awready);
            o_wready <= ~w_ok & ~o_bvalid & ~(i_wvalid & o_wready);
            if (i_awvalid & o_awready) begin
                aw_held <= 1'b1;
                aw_q <= i_awaddr;
            end
            if (i_wvalid & o_wready) begin
                w_held <= 1'b1;
                w_q <= i_wdata;
                ws_q <= i_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                o_awready <= 1'b0;
                o_wready <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= wr_map ? crr_pkg::RESP_OKAY : crr_pkg::RESP_SLVERR;
            end else if (o_bvalid & i_bready) begin
                o_bvalid <= 1'b0;
            end
        end
    end

    // Register update: reset events over wake-up over software writes
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < crr_pkg::NREG; i++) begin
                regs[i] <= crr_pkg::RST_VAL[i];
            end
            pcu <= 8'h00;
            pch <= 8'h00;
        end else if (evt.kind == crr_pkg::EV_POR) begin
            for (int i = 0; i < crr_pkg::NREG; i++) begin
                regs[i] <= (regs[i] & ~crr_pkg::POR_MASK[i]) |
                    (crr_pkg::RST_VAL[i] & crr_pkg::POR_MASK[i]);
            end
            pcu <= 8'h00;
            pch <= 8'h00;
        end else if (evt.kind == crr_pkg::EV_HARD) begin
            for (int i = 0; i < crr_pkg::NREG; i++) begin
                regs[i] <= (regs[i] & ~crr_pkg::HARD_MASK[i]) |
                    (crr_pkg::RST_VAL[i] & crr_pkg::HARD_MASK[i]);
            end
            pcu <= 8'h00;
            pch <= 8'h00;
        end else if (is_irq | is_wdt) begin
            // Only PC, stack and one flag move; the rest is held
            if (vec_go) begin
                regs[crr_pkg::IX_TOP_U] <= {3'h0, pc[20:16]};
                regs[crr_pkg::IX_TOP_H] <= pc[15:8];
                regs[crr_pkg::IX_TOP_L] <= pc[7:0];
                regs[crr_pkg::IX_STKP] <= {sp_full,
                    regs[crr_pkg::IX_STKP][6:5], sp_next};
            end
            pcu <= {3'h0, pc_wake[20:16]};
            pch <= pc_wake[15:8];
            regs[crr_pkg::IX_PC_LOW] <= pc_wake[7:0];
            regs[crr_pkg::IX_IRQ_CTL][is_irq ? crr_pkg::IRQ_FLAG_BIT :
                crr_pkg::WDT_FLAG_BIT] <= 1'b1;
        end else if (wr_do) begin
            if (wi == crr_pkg::IX_PCU) pcu <= w_now[7:0] & 8'h1F;
            else if (wi == crr_pkg::IX_PCH) pch <= w_now[7:0];
            else if (wi < 5'(crr_pkg::NREG))
                regs[wi] <= w_now[7:0] & crr_pkg::IMPL[wi];
        end
    end

    // Last event seen, readable by software
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_last <= 3'h0;
            o_wake_done <= 1'b0;
        end else begin
            if (evt.kind != crr_pkg::EV_NONE) evt_last <= evt.kind;
            o_wake_done <= is_irq | is_wdt;
        end
    end

    // Read channel: one outstanding read, answered one cycle after address
    wire [4:0] ri = idx_of(i_araddr);
    wire rd_map = map_ok(i_araddr);
    wire [7:0] rd_val = ri == crr_pkg::IX_PCU ? pcu :
        ri == crr_pkg::IX_PCH ? pch :
        ri == crr_pkg::IX_EVT ? {5'h00, evt_last} :
        rd_reg(ri, regs[ri < 5'(crr_pkg::NREG) ? ri : 5'h00]);
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= crr_pkg::RESP_OKAY;
        end else begin
            o_arready <= ~o_rvalid & ~(i_arvalid & o_arready);
            if (i_arvalid & o_arready) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= rd_map ? {24'h000000, rd_val} : 32'h0000_0000;
                o_rresp <= rd_map ? crr_pkg::RESP_OKAY : crr_pkg::RESP_SLVERR;
            end else if (o_rvalid & i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end
endmodule : crr_top
`default_nettype wire

// File: tb/crr_top_asserts.sv
// Checker of bus handshake and wake-up timing at the top ports
`timescale 1ns/1ps
`default_nettype none
module crr_asserts (
    // Clock, reset and wake pins
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wake_wdt,
    input wire logic i_wake_irq,
    // Bus
    input wire logic i_awvalid,
    input wire logic i_bready,
    input wire logic i_arvalid,
    input wire logic i_rready,
    input wire logic o_awready,
    input wire logic o_wready,
    input wire logic o_bvalid,
    input wire logic o_arready,
    input wire logic [31:0] o_rdata,
    input wire logic [1:0] o_rresp,
    input wire logic o_rvalid,
    // Status
    input wire logic o_wake_done
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_rd_take;
        i_arvalid && o_arready;
    endsequence
    sequence s_wake;
        $rose(i_wake_wdt) || $rose(i_wake_irq);
    endsequence
    property p_rd_ans;
        s_rd_take |=> o_rvalid;
    endproperty
    property p_r_once;
        o_rvalid && i_rready |=> !o_rvalid;
    endproperty
    property p_b_once;
        o_bvalid && i_bready |=> !o_bvalid;
    endproperty
    property p_r_quiet;
        o_rvalid |-> !o_arready;
    endproperty
    property p_b_quiet;
        o_bvalid |-> !o_awready && !o_wready;
    endproperty
    property p_upper0;
        o_rvalid |-> o_rdata[31:8] == 24'h000000;
    endproperty
    property p_err0;
        o_rvalid && o_rresp == crr_pkg::RESP_SLVERR |-> o_rdata == 32'h0;
    endproperty
    property p_wake;
        s_wake |-> ##[2:6] o_wake_done;
    endproperty
    property p_done1;
        o_wake_done |=> !o_wake_done;
    endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    a_r_once: assert property (p_r_once) else $error("rvalid repeated");
    a_b_once: assert property (p_b_once) else $error("bvalid repeated");
    a_r_quiet: assert property (p_r_quiet) else $error("arready early");
    a_b_quiet: assert property (p_b_quiet) else $error("write ready early");
    a_upper0: assert property (p_upper0) else $error("upper bits set");
    a_err0: assert property (p_err0) else $error("error data nonzero");
    a_wake: assert property (p_wake) else $error("wake not applied");
    a_done1: assert property (p_done1) else $error("wake done too long");
endmodule : crr_asserts
bind crr_top crr_asserts u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_wake_wdt(i_wake_wdt), .i_wake_irq(i_wake_irq),
    .i_awvalid(i_awvalid), .i_bready(i_bready), .i_arvalid(i_arvalid),
    .i_rready(i_rready), .o_awready(o_awready), .o_wready(o_wready),
    .o_bvalid(o_bvalid), .o_arready(o_arready), .o_rdata(o_rdata),
    .o_rresp(o_rresp), .o_rvalid(o_rvalid), .o_wake_done(o_wake_done));
`default_nettype wire

// File: tb/crr_top_tb.sv
// Self-checking bench for the core register bank
`timescale 1ns/1ps
`default_nettype none
module crr_top_tb;
    logic i_clk, i_rst_n, i_por, i_hard, i_wake_wdt, i_wake_irq, i_irq_high;
    logic i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_wake_done;
    logic [7:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata, dat;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp, rs;
    int err_count = 0;
    int num_checks = 0;
    crr_top uut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_por(i_por),
        .i_hard(i_hard), .i_wake_wdt(i_wake_wdt), .i_wake_irq(i_wake_irq),
        .i_irq_high(i_irq_high), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
        .o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
        .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
        .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr),
        .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
        .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready),
        .o_wake_done(o_wake_done));
    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string nm, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("mismatch %s exp %0h seen %0h", nm, e, s);
        end
    endtask : chk
    // Every bus wait is bounded; a hang ends the run as a failure
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge i_clk);
        n = 0;
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
            if (o_awready) i_awvalid <= 1'b0;
            if (o_wready) i_wvalid <= 1'b0;
        end while (!o_bvalid && n < 40);
        i_bready <= 1'b0;
        rs = o_bresp;
        if (!o_bvalid) begin
            err_count++;
            complete_run();
        end
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge i_clk);
        n = 0;
        i_araddr <= a;
        i_arvalid <= 1'b1;
        i_rready <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
            if (o_arready) i_arvalid <= 1'b0;
        end while (!o_rvalid && n < 40);
        i_rready <= 1'b0;
        dat = o_rdata;
        rs = o_rresp;
        if (!o_rvalid) begin
            err_count++;
            complete_run();
        end
    endtask : rd
    task automatic rc(input string nm, input logic [7:0] a,
        input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF);
        rd(a);
        chk(nm, dat & m, e);
    endtask : rc
    // Pin held two cycles, then the fixed sync and apply latency is waited
    task automatic ev(input int k);
        @(posedge i_clk);
        case (k)
            0: i_por <= 1'b1;
            1: i_hard <= 1'b1;
            2: i_wake_wdt <= 1'b1;
            default: i_wake_irq <= 1'b1;
        endcase
        repeat (2) @(posedge i_clk);
        {i_por, i_hard, i_wake_wdt, i_wake_irq} <= 4'h0;
        repeat (6) @(posedge i_clk);
    endtask : ev
    task automatic t_reset;
        rc("tos_upper", 8'h00, 32'h00);
        rc("irq_ctl2", 8'h38, 32'hFF);
        rc("irq_ctl3", 8'h3C, 32'hC0);
        rc("unmapped", 8'h64, 32'h00);
        chk("rresp", 32'(rs), 32'(crr_pkg::RESP_SLVERR));
        wr(8'h01, 32'h00);
        chk("bresp", 32'(rs), 32'(crr_pkg::RESP_SLVERR));
        $display("test reset done");
    endtask : t_reset
    task automatic t_mask;
        logic [7:0] a [3] = '{8'h00, 8'h1C, 8'h54};
        logic [7:0] e [3] = '{8'h1F, 8'h3F, 8'h0F};
        for (int i = 0; i < 3; i++) begin
            wr(a[i], 32'hFFFFFFFF);
            rc("impl_bits", a[i], 32'(e[i]));
        end
        // Byte lane 0 off: the write is answered but must not land
        i_wstrb <= 4'h0;
        wr(8'h54, 32'h00);
        i_wstrb <= 4'hF;
        rc("strb_off", 8'h54, 32'h0F);
        $display("test mask done");
    endtask : t_mask
    task automatic t_wake;
        wr(8'h1C, 32'h15);
        for (int k = 2; k < 4; k++) begin
            wr(8'h34, 32'h00);
            wr(8'h18, 32'h40);
            ev(k);
            rc("pc_resume", 8'h18, 32'h42);
            rc("wake_flag", 8'h34, k == 2 ? 32'h04 : 32'h02, 32'h06);
            rc("tbl_kept", 8'h1C, 32'h15);
            rc("stk_kept", 8'h0C, 32'h00);
            rc("evt_code", 8'h60, k == 2 ? 32'h2 : 32'h6);
        end
        $display("test wake done");
    endtask : t_wake
    task automatic t_irq;
        for (int i = 0; i < 2; i++) begin
            wr(8'h34, i ? 32'h40 : 32'h80);
            wr(8'h18, 32'h50);
            i_irq_high <= (i == 0);
            ev(3);
            rc("tos_low", 8'h08, 32'h50);
            rc("tos_upper", 8'h00, 32'h00);
            rc("stk_ptr", 8'h0C, 32'(i + 1), 32'h1F);
            rc("vector", 8'h18, i ? 32'h18 : 32'h08);
            rc("irq_flag", 8'h34, 32'h02, 32'h02);
        end
        $display("test irq done");
    endtask : t_irq
    task automatic t_rst;
        for (int k = 0; k < 2; k++) begin
            wr(8'h38, 32'h00);
            wr(8'h2C, 32'h5A);
            wr(8'h18, 32'h33);
            ev(k);
            rc("irq_ctl2", 8'h38, 32'hFF);
            rc("pc_low", 8'h18, 32'h00);
            rc("prod_kept", 8'h2C, 32'h5A);
            rc("stk_ptr", 8'h0C, 32'h00, 32'h1F);
            rc("evt_code", 8'h60, k ? 32'h3 : 32'h1);
        end
        $display("test resets done");
    endtask : t_rst
    initial begin
        {i_por, i_hard, i_wake_wdt, i_wake_irq, i_irq_high} = 5'h00;
        {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
        i_awaddr = 8'h00;
        i_araddr = 8'h00;
        i_wdata = 32'h0;
        i_wstrb = 4'hF;
        i_rst_n = 1'b0;
        repeat (3) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        t_reset();
        t_mask();
        t_wake();
        t_irq();
        t_rst();
        complete_run();
    end
endmodule : crr_top_tb
`default_nettype wire
